// ===== include/wk_pkg.sv
// Shared constants for the wake-up event and pattern match block.
// Assumes a 16-bit register port with separate strobes per register space.
`default_nettype none
package wk_pkg;
  // Register locations in the three register spaces.
  localparam logic [7:0] PM_CSR_OFF   = 8'h44;
  localparam logic [7:0] WAKE_CSR_IDX = 8'h74;
  localparam logic [7:0] PAT_ADDR_IDX = 8'h2d;
  localparam logic [7:0] PAT_LO_IDX   = 8'h2e;
  localparam logic [7:0] PAT_HI_IDX   = 8'h2f;
  // Power management control/status fields.
  localparam int PM_STS_BIT = 15;
  localparam int PM_EN_BIT  = 8;
  localparam int PM_PS_LSB  = 0;
  localparam logic [1:0] PM_PS_RST = 2'h0;
  // Wake control register fields.
  localparam int WC_FRAME_BIT = 5;
  localparam int WC_MATCH_BIT = 7;
  localparam int WC_LCM_BIT   = 8;
  localparam int WC_LCD_BIT   = 9;
  localparam int WC_OVR_BIT   = 10;
  // Pattern address register fields.
  localparam int PA_MODE_BIT = 7;
  localparam logic [15:0] PA_MODE_READ = 16'h0080;
  // Pattern RAM geometry and word layout.
  localparam int RAM_WORDS = 64;
  localparam int RAM_AW    = 6;
  localparam int RAM_DW    = 40;
  localparam int NPAT      = 8;
  localparam int CTRL_LAST_BIT = 7;
  localparam int CTRL_SKIP_LSB = 4;
  localparam int CTRL_SKIP_W   = 3;
  localparam int CTRL_MASK_LSB = 0;
  localparam int HDR_PTRS_PER_WORD = 4;
  localparam logic [RAM_AW-1:0] HDR_WORD0 = 6'h00;
  localparam logic [RAM_AW-1:0] HDR_WORD1 = 6'h01;
  localparam logic [RAM_AW-1:0] LAST_WORD = 6'h3f;
  localparam logic [15:0] RD_ZERO = 16'h0000;
endpackage : wk_pkg
`default_nettype wire

// ===== logic/wk_match.sv
// One pattern matcher: walks its pattern words one frame Dword at a time.
// Assumes the RAM word at addr is returned in the same cycle and is frozen while enabled.
`default_nettype none
module wk_match (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Control.
  input  wire logic                          en,
  input  wire logic [wk_pkg::RAM_AW-1:0]     ptr,
  // Frame stream.
  input  wire logic                          rx_valid,
  input  wire logic                          rx_sof,
  input  wire logic                          rx_eof,
  input  wire logic [31:0]                   rx_data,
  // RAM access and result.
  output logic      [wk_pkg::RAM_AW-1:0]     addr,
  input  wire logic [wk_pkg::RAM_DW-1:0]     word,
  output logic                               hit
);
  typedef enum logic [2:0] {
    WKM_IDLE = 3'b001,
    WKM_RUN  = 3'b010,
    WKM_DONE = 3'b100
  } wk_mst_e;

  typedef struct packed {
    wk_mst_e                           st;
    logic [wk_pkg::RAM_AW-1:0]         cur;
    logic                              fresh;
    logic [wk_pkg::CTRL_SKIP_W-1:0]    skip;
    logic                              hit;
  } wk_mst_s;

  wk_mst_s s_q, s_d;
  logic                           go;
  logic                           same;
  logic [wk_pkg::CTRL_SKIP_W-1:0] skipv;

  always_comb begin
    s_d = s_q;
    s_d.hit = 1'b0;
    go = 1'b0;
    same = 1'b1;
    skipv = s_q.fresh ? word[wk_pkg::CTRL_SKIP_LSB +: wk_pkg::CTRL_SKIP_W] : s_q.skip;
    for (int i = 0; i < 4; i++) begin
      if (word[wk_pkg::CTRL_MASK_LSB + i] && (word[8*i+8 +: 8] != rx_data[8*i +: 8])) begin
        same = 1'b0; // R21
      end
    end
    unique case (s_q.st)
      WKM_IDLE: begin
        s_d.cur = ptr;
        s_d.fresh = 1'b1;
        go = en && rx_valid && rx_sof; // R24
      end
      WKM_RUN: begin
        if (!en) s_d.st = WKM_IDLE;
        else go = rx_valid;
      end
      WKM_DONE: begin
        if (!en || (rx_valid && (rx_eof || rx_sof))) s_d.st = WKM_IDLE;
      end
      default: s_d.st = WKM_IDLE;
    endcase
    if (go) begin
      if (skipv != '0) begin
        s_d.skip = skipv - 1'b1; // R20
        s_d.fresh = 1'b0;
        s_d.st = WKM_RUN;
      end else if (!same) begin
        s_d.st = WKM_DONE;
      end else if (word[wk_pkg::CTRL_LAST_BIT]) begin
        s_d.hit = 1'b1; // R19
        s_d.st = WKM_DONE;
      end else if (s_q.cur == wk_pkg::LAST_WORD) begin
        s_d.st = WKM_DONE;
      end else begin
        s_d.cur = s_q.cur + 1'b1; // R24
        s_d.fresh = 1'b1;
        s_d.st = WKM_RUN;
      end
      if (rx_eof) s_d.st = WKM_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{st: WKM_IDLE, cur: '0, fresh: 1'b1, skip: '0, hit: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign addr = s_q.cur;
  assign hit  = s_q.hit;

  a_hit_enabled: assert property (@(posedge clk) disable iff (!rst_n) hit |-> $past(en)) // R10
    else $error("pattern hit while matcher disabled");
endmodule // wk_match
`default_nettype wire

// ===== logic/wk_ram.sv
// Pattern RAM: one write port, several asynchronous read ports, two fixed header taps.
// Assumes the writer holds off while matching runs; contents have no reset on purpose.
`default_nettype none
module wk_ram #(
  parameter int NRD = 9
) (
  // Clock.
  input  wire logic                                   clk,
  // Write port.
  input  wire logic                                   we,
  input  wire logic [wk_pkg::RAM_AW-1:0]              waddr,
  input  wire logic [wk_pkg::RAM_DW-1:0]              wdata,
  // Read ports.
  input  wire logic [NRD-1:0][wk_pkg::RAM_AW-1:0]     raddr,
  output logic      [NRD-1:0][wk_pkg::RAM_DW-1:0]     rdata,
  output logic      [wk_pkg::RAM_DW-1:0]              hdr0,
  output logic      [wk_pkg::RAM_DW-1:0]              hdr1
);
  logic [wk_pkg::RAM_DW-1:0] mem [wk_pkg::RAM_WORDS];

  // No reset: patterns must survive every reset short of power loss.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata; // R12 R22
    end
  end

  always_comb begin
    for (int i = 0; i < NRD; i++) begin
      rdata[i] = mem[raddr[i]];
    end
    hdr0 = mem[wk_pkg::HDR_WORD0];
    hdr1 = mem[wk_pkg::HDR_WORD1];
  end
endmodule // wk_ram
`default_nettype wire

// ===== logic/wk_wake.sv
// Wake-up event logic: power management status, link change and pattern match wake.
// Assumes register strobes and frame Dwords are synchronous to clk; read data follows one cycle later.
//
// How it works
// R1: Any wake event sets the wake status bit, which drives the wake output.
// R2: Software enables the wake output by writing the wake enable bit.
// R3: Writing wake status as 0 clears it and drops the wake output.
// R4: Three wake sources: special wake frame, pattern match, link change.
// R5: Pattern and link change wake work only when the MII port is in use.
// R6: Link change mode bit is written by software or loaded from config memory.
// R7: With link change mode on, any link change sets the link change flag.
// R8: Link change flag raises the remote wake output and sets wake status.
// R9: On link change the wake output follows enable or enable override.
// R10: Pattern mode compares frames against up to eight stored patterns, flags match.
// R11: Pattern match sets wake status; output only when wake enable is set.
// R12: Pattern RAM is 64 by 40 bits, reached only through three registers.
// R13: Pattern mode bit set enables matching and blocks all RAM access.
// R14: Pattern mode bit clear stops matching; low address bits select RAM word.
// R15: Addressed word reads back through address and two data registers.
// R16: RAM word is written only by address, low, then high register writes.
// R17: Word 0 byte 0 holds the per-pattern enable bits.
// R18: Words 0 and 1 bytes 1 to 4 point to pattern start words.
// R19: In pattern words, control bit 7 marks the last word.
// R20: Control bits 6 to 4 give frame Dwords skipped before comparing.
// R21: Control bits 3 to 0 mask pattern bytes out of the compare.
// R22: Pattern RAM keeps its contents across every reset but power up.
// R23: Special wake frame sets its flag, wake status and remote wake output.
// R24: Patterns compare one frame Dword per word from frame start, independently.
`default_nettype none
module wk_wake (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Register port.
  input  wire logic         cfg_wr,
  input  wire logic         cfg_rd,
  input  wire logic         csr_wr,
  input  wire logic         csr_rd,
  input  wire logic         bcr_wr,
  input  wire logic         bcr_rd,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [15:0]  reg_wdata,
  output logic      [15:0]  reg_rdata,
  output logic              reg_rvalid,
  // Configuration memory load.
  input  wire logic         cfg_load,
  input  wire logic         cfg_link_change_mode,
  // Network side.
  input  wire logic         port_is_mii,
  input  wire logic         link_up,
  input  wire logic         wake_frame_det,
  input  wire logic         rx_valid,
  input  wire logic         rx_sof,
  input  wire logic         rx_eof,
  input  wire logic [31:0]  rx_data,
  // Wake outputs.
  output logic              pme_o,
  output logic              pme_oe,
  output logic              remote_wake_output
);
  localparam int NRD = wk_pkg::NPAT + 1;

  typedef struct packed {
    logic                      pme_sts;
    logic                      pme_en;
    logic [1:0]                pstate;
    logic                      link_change_mode;
    logic                      link_change_detected;
    logic                      pattern_matched_flag;
    logic                      wake_enable_override;
    logic                      frame_wake_flag;
    logic                      link_seen;
    logic                      link_valid;
    logic                      pattern_mode_bit;
    logic [6:0]                pat_addr;
    logic [7:0]                pat_b0;
    logic [15:0]               pat_lo;
    logic                      lo_ok;
    logic [15:0]               rdata;
    logic                      rvalid;
    logic                      wake_pin;
  } wk_state_s;

  wk_state_s s_q, s_d;

  logic                                         w_pm, w_wctl, w_paddr, w_plo, w_phi;
  logic                                         lc_evt, pm_evt, wf_evt;
  logic                                         ram_we;
  logic [wk_pkg::RAM_DW-1:0]                    ram_wdata, hdr0, hdr1;
  logic [NRD-1:0][wk_pkg::RAM_AW-1:0]           raddr;
  logic [NRD-1:0][wk_pkg::RAM_DW-1:0]           rdata;
  logic [wk_pkg::NPAT-1:0]                      hits;
  logic                                         match_on;
  logic [15:0]                                  rd_mux;

  assign w_pm    = cfg_wr && (reg_addr == wk_pkg::PM_CSR_OFF);
  assign w_wctl  = csr_wr && (reg_addr == wk_pkg::WAKE_CSR_IDX);
  assign w_paddr = bcr_wr && (reg_addr == wk_pkg::PAT_ADDR_IDX);
  assign w_plo   = bcr_wr && (reg_addr == wk_pkg::PAT_LO_IDX);
  assign w_phi   = bcr_wr && (reg_addr == wk_pkg::PAT_HI_IDX);

  // Matchers only run with pattern mode on and the MII port selected.
  assign match_on = s_q.pattern_mode_bit && port_is_mii; // R5 R13 R14

  // Events.
  assign lc_evt = s_q.link_change_mode && port_is_mii && s_q.link_valid &&
                  (link_up != s_q.link_seen); // R5 R6 R7
  assign pm_evt = match_on && (|hits); // R10
  assign wf_evt = wake_frame_det; // R4 R23

  // A high write commits only after a low write with no address or high write since, and with no mode set.
  assign ram_we    = w_phi && s_q.lo_ok && !s_q.pattern_mode_bit; // R13 R16
  assign ram_wdata = {reg_wdata, s_q.pat_lo, s_q.pat_b0};

  wk_ram #(
    .NRD (NRD)
  ) u_ram (
    .clk   (clk),
    .we    (ram_we),
    .waddr (s_q.pat_addr[wk_pkg::RAM_AW-1:0]), // R14
    .wdata (ram_wdata),
    .raddr (raddr),
    .rdata (rdata),
    .hdr0  (hdr0),
    .hdr1  (hdr1)
  );

  assign raddr[wk_pkg::NPAT] = s_q.pat_addr[wk_pkg::RAM_AW-1:0]; // R15

  for (genvar g = 0; g < wk_pkg::NPAT; g++) begin : g_pat
    logic [wk_pkg::RAM_DW-1:0] hdr;
    logic [wk_pkg::RAM_AW-1:0] ptr;
    assign hdr = (g < wk_pkg::HDR_PTRS_PER_WORD) ? hdr0 : hdr1;
    assign ptr = hdr[8*((g % wk_pkg::HDR_PTRS_PER_WORD) + 1) +: wk_pkg::RAM_AW]; // R18
    wk_match u_match (
      .clk      (clk),
      .rst_n    (rst_n),
      .en       (match_on && hdr0[g]), // R17
      .ptr      (ptr),
      .rx_valid (rx_valid),
      .rx_sof   (rx_sof),
      .rx_eof   (rx_eof),
      .rx_data  (rx_data),
      .addr     (raddr[g]),
      .word     (rdata[g]),
      .hit      (hits[g])
    );
  end

  // Read data selection.
  always_comb begin
    rd_mux = wk_pkg::RD_ZERO;
    if (cfg_rd && reg_addr == wk_pkg::PM_CSR_OFF) begin
      rd_mux[wk_pkg::PM_STS_BIT] = s_q.pme_sts;
      rd_mux[wk_pkg::PM_EN_BIT] = s_q.pme_en;
      rd_mux[wk_pkg::PM_PS_LSB +: 2] = s_q.pstate;
    end else if (csr_rd && reg_addr == wk_pkg::WAKE_CSR_IDX) begin
      rd_mux[wk_pkg::WC_FRAME_BIT] = s_q.frame_wake_flag;
      rd_mux[wk_pkg::WC_MATCH_BIT] = s_q.pattern_matched_flag;
      rd_mux[wk_pkg::WC_LCM_BIT] = s_q.link_change_mode;
      rd_mux[wk_pkg::WC_LCD_BIT] = s_q.link_change_detected;
      rd_mux[wk_pkg::WC_OVR_BIT] = s_q.wake_enable_override;
    end else if (bcr_rd && s_q.pattern_mode_bit) begin
      // Undefined bits read as zero while matching owns the RAM.
      if (reg_addr == wk_pkg::PAT_ADDR_IDX) rd_mux = wk_pkg::PA_MODE_READ; // R13
    end else if (bcr_rd) begin
      unique case (reg_addr)
        wk_pkg::PAT_ADDR_IDX: rd_mux = {rdata[wk_pkg::NPAT][7:0], 1'b0, s_q.pat_addr}; // R15
        wk_pkg::PAT_LO_IDX:   rd_mux = rdata[wk_pkg::NPAT][23:8];
        wk_pkg::PAT_HI_IDX:   rd_mux = rdata[wk_pkg::NPAT][39:24];
        default:              rd_mux = wk_pkg::RD_ZERO;
      endcase
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.rdata = rd_mux;
    s_d.rvalid = cfg_rd || csr_rd || bcr_rd;
    s_d.link_seen = link_up;
    s_d.link_valid = 1'b1;
    // Software writes first, so that an event in the same cycle still lands.
    if (w_pm) begin
      s_d.pme_en = reg_wdata[wk_pkg::PM_EN_BIT]; // R2
      s_d.pstate = reg_wdata[wk_pkg::PM_PS_LSB +: 2];
      if (!reg_wdata[wk_pkg::PM_STS_BIT]) s_d.pme_sts = 1'b0; // R3
    end
    if (w_wctl) begin
      s_d.link_change_mode = reg_wdata[wk_pkg::WC_LCM_BIT]; // R6
      s_d.wake_enable_override = reg_wdata[wk_pkg::WC_OVR_BIT];
      if (reg_wdata[wk_pkg::WC_LCD_BIT]) s_d.link_change_detected = 1'b0;
      if (reg_wdata[wk_pkg::WC_MATCH_BIT]) s_d.pattern_matched_flag = 1'b0;
      if (reg_wdata[wk_pkg::WC_FRAME_BIT]) s_d.frame_wake_flag = 1'b0;
    end
    if (cfg_load) s_d.link_change_mode = cfg_link_change_mode; // R6
    // Pattern register sequencing.
    if (w_paddr) begin
      s_d.pattern_mode_bit = reg_wdata[wk_pkg::PA_MODE_BIT]; // R13 R14
      if (!reg_wdata[wk_pkg::PA_MODE_BIT]) begin
        s_d.pat_addr = reg_wdata[6:0]; // R14
        s_d.pat_b0 = reg_wdata[15:8];
      end
      s_d.lo_ok = 1'b0;
    end else if (w_plo && !s_q.pattern_mode_bit) begin
      s_d.pat_lo = reg_wdata; // R16
      s_d.lo_ok = 1'b1;
    end else if (w_phi) begin
      s_d.lo_ok = 1'b0;
    end
    // Hardware events win over any clear in the same cycle.
    if (lc_evt) s_d.link_change_detected = 1'b1; // R7
    if (pm_evt) s_d.pattern_matched_flag = 1'b1; // R10
    if (wf_evt) s_d.frame_wake_flag = 1'b1; // R23
    if (lc_evt || pm_evt || wf_evt) s_d.pme_sts = 1'b1; // R1 R8 R11 R23
    s_d.wake_pin = s_d.link_change_detected || s_d.frame_wake_flag; // R8 R23
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '{pstate: wk_pkg::PM_PS_RST, rdata: wk_pkg::RD_ZERO, pat_b0: '0, pat_lo: '0, pat_addr: '0,
               default: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // The pin is open drain: it only ever pulls low.
  assign pme_o  = 1'b0;
  assign pme_oe = s_q.pme_sts && (s_q.pme_en || (s_q.wake_enable_override && s_q.link_change_detected)); // R9 R11
  assign remote_wake_output = s_q.wake_pin;
  assign reg_rdata  = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_lc_sets_det: assert property (lc_evt |=> s_q.link_change_detected && s_q.pme_sts) // R7
    else $error("link change did not set flag and status");
  a_evt_sets_sts: assert property ((pm_evt || wf_evt) |=> s_q.pme_sts) // R1
    else $error("wake event did not set status");
  a_pme_needs_en: assert property ((!s_q.pme_en && !s_q.wake_enable_override) |-> !pme_oe) // R11
    else $error("wake output without enable");
  a_ovr_on_lc: assert property (lc_evt && s_q.wake_enable_override |=> pme_oe) // R9
    else $error("override did not raise wake output on link change");
  a_sts_clear: assert property ((w_pm && !reg_wdata[wk_pkg::PM_STS_BIT] && !lc_evt && !pm_evt && !wf_evt)
                                |=> !s_q.pme_sts && !pme_oe) // R3
    else $error("status write of zero did not clear");
  a_rwu_follows: assert property (s_q.link_change_detected |-> remote_wake_output) // R8
    else $error("remote wake not raised by link change flag");
  a_mii_only: assert property (!port_is_mii |-> !lc_evt && !pm_evt) // R5
    else $error("wake from MII-only source on other port");
  a_link_change_mode_gate: assert property (!s_q.link_change_mode |-> !lc_evt) // R6
    else $error("link change seen with mode off");
  a_mode_blocks: assert property (s_q.pattern_mode_bit |-> !ram_we) // R13
    else $error("pattern RAM written in pattern mode");
  a_write_order: assert property (ram_we |-> !$past(w_paddr) && !$past(s_q.pattern_mode_bit)) // R16
    else $error("pattern RAM written out of order");
  a_mode_read: assert property ((bcr_rd && s_q.pattern_mode_bit && reg_addr == wk_pkg::PAT_ADDR_IDX)
                                |=> reg_rdata == wk_pkg::PA_MODE_READ && reg_rvalid) // R13
    else $error("address register read in pattern mode wrong");

  c_link_wake:  cover property (lc_evt ##1 pme_oe);
  c_pat_wake:   cover property (pm_evt ##1 s_q.pme_sts);
  c_ram_write:  cover property (w_paddr ##[1:4] w_plo ##[1:4] ram_we);
  c_sts_clear:  cover property (s_q.pme_sts ##1 !s_q.pme_sts);
endmodule // wk_wake
`default_nettype wire

// ===== tb/wake_event_pattern_match_test.sv
// Self-checking bench for the wake-up event and pattern match block.
// Assumes the host model drives the register port; frames and link come from here.
`default_nettype none
module wake_event_pattern_match_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0] SP_CFG = 2'h0;
  localparam logic [1:0] SP_CSR = 2'h1;
  localparam logic [1:0] SP_BCR = 2'h2;
  logic        clk, rst_n, cfg_load, cfg_lcm, mii, link_up, wf_det;
  logic        rx_valid, rx_sof, rx_eof, reg_rvalid, pme_o, pme_oe, rwake, pme_line_n;
  logic [31:0] rx_data;
  logic [2:0]  wr_stb, rd_stb;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  int          miscompares, tests_run;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  wk_wake i_wk_wake (
    .clk(clk), .rst_n(rst_n), .cfg_wr(wr_stb[0]), .cfg_rd(rd_stb[0]), .csr_wr(wr_stb[1]),
    .csr_rd(rd_stb[1]), .bcr_wr(wr_stb[2]), .bcr_rd(rd_stb[2]), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .cfg_load(cfg_load),
    .cfg_link_change_mode(cfg_lcm), .port_is_mii(mii), .link_up(link_up), .wake_frame_det(wf_det),
    .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof), .rx_data(rx_data), .pme_o(pme_o),
    .pme_oe(pme_oe), .remote_wake_output(rwake));

  wk_host i_wk_host (
    .clk(clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pme_o(pme_o), .pme_oe(pme_oe),
    .pme_line_n(pme_line_n));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(input string what, input logic [1:0] k, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    i_wk_host.rd(k, a, v);
    check(what, exp, v);
  endtask
  task automatic wr(input logic [1:0] k, input logic [7:0] a, input logic [15:0] d);
    i_wk_host.wr(k, a, d);
  endtask
  task automatic prog(input logic [7:0] a, input logic [7:0] b0, input logic [15:0] lo, input logic [15:0] hi);
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, {b0, a});
    wr(SP_BCR, wk_pkg::PAT_LO_IDX, lo);
    wr(SP_BCR, wk_pkg::PAT_HI_IDX, hi);
  endtask
  task automatic pulse_load(input logic v);
    cfg_lcm = v;
    @(posedge clk);
    #1;
    cfg_load = 1'b1;
    @(posedge clk);
    #1;
    cfg_load = 1'b0;
  endtask
  task automatic toggle_link;
    @(posedge clk);
    #1;
    link_up = ~link_up;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Idle data shows the inverse of the last Dword so a stale value never matches.
  task automatic frame(input logic [31:0] a, input logic [31:0] b);
    @(posedge clk);
    #1;
    rx_valid = 1'b1;
    rx_sof = 1'b1;
    rx_data = a;
    @(posedge clk);
    #1;
    rx_sof = 1'b0;
    rx_eof = 1'b1;
    rx_data = b;
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_eof = 1'b0;
    rx_data = ~b;
    repeat (3) @(posedge clk);
  endtask
  task automatic done(input string name);
    $display("test %s done, %0d compares so far", name, tests_run);
  endtask

  task automatic t_reset;
    rchk("power status", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0000);
    rchk("wake control", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0000);
    rchk("unmapped", SP_BCR, 8'h30, 16'h0000);
    check("wake line", 16'h0001, {15'h0, pme_line_n});
    done("reset");
  endtask
  task automatic t_load;
    pulse_load(1'b1);
    rchk("mode loaded", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0100);
    pulse_load(1'b0);
    rchk("mode cleared", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0000);
    done("load");
  endtask
  task automatic t_ram;
    prog(8'h03, 8'h11, 16'h5a5a, 16'ha5c3);
    rchk("addr read", SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h1103);
    rchk("low read", SP_BCR, wk_pkg::PAT_LO_IDX, 16'h5a5a);
    rchk("high read", SP_BCR, wk_pkg::PAT_HI_IDX, 16'ha5c3);
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h2203);
    wr(SP_BCR, wk_pkg::PAT_HI_IDX, 16'h1234);
    rchk("high no low", SP_BCR, wk_pkg::PAT_HI_IDX, 16'ha5c3);
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h0080);
    rchk("mode addr", SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h0080);
    rchk("mode low", SP_BCR, wk_pkg::PAT_LO_IDX, 16'h0000);
    wr(SP_BCR, wk_pkg::PAT_LO_IDX, 16'hffff);
    wr(SP_BCR, wk_pkg::PAT_HI_IDX, 16'hffff);
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h0003);
    rchk("low kept", SP_BCR, wk_pkg::PAT_LO_IDX, 16'h5a5a);
    rchk("high kept", SP_BCR, wk_pkg::PAT_HI_IDX, 16'ha5c3);
    done("ram");
  endtask
  task automatic t_retain;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst_n = 1'b1;
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h0003);
    rchk("low retained", SP_BCR, wk_pkg::PAT_LO_IDX, 16'h5a5a);
    rchk("high retained", SP_BCR, wk_pkg::PAT_HI_IDX, 16'ha5c3);
    done("retain");
  endtask
  task automatic t_wake_frame;
    check("remote wake idle", 16'h0000, {15'h0, rwake});
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0003);
    @(posedge clk);
    #1;
    wf_det = 1'b1;
    @(posedge clk);
    #1;
    wf_det = 1'b0;
    rchk("frame flag", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0020);
    rchk("frame status", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h8003);
    check("remote wake", 16'h0001, {15'h0, rwake});
    wr(SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0020);
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0000);
    rchk("status cleared", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0000);
    done("wake_frame");
  endtask
  task automatic t_link;
    wr(SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0100);
    toggle_link();
    rchk("no mii", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0100);
    mii = 1'b1;
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0100);
    toggle_link();
    check("remote wake", 16'h0001, {15'h0, rwake});
    check("wake line", 16'h0000, {15'h0, pme_line_n});
    rchk("link flag", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0300);
    rchk("link status", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h8100);
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0100);
    check("line released", 16'h0001, {15'h0, pme_line_n});
    rchk("status clear", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0100);
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0000);
    wr(SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0700);
    toggle_link();
    check("override line", 16'h0000, {15'h0, pme_line_n});
    rchk("override status", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h8000);
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0000);
    wr(SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0200);
    rchk("flags cleared", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0000);
    done("link");
  endtask
  task automatic t_match;
    prog(8'h00, 8'h01, 16'h0002, 16'h0000);
    prog(8'h02, 8'h8f, 16'hbeef, 16'hdead);
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0100);
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h0080);
    frame(32'hdeadbeee, 32'h00000000);
    rchk("no match", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0000);
    check("line idle", 16'h0001, {15'h0, pme_line_n});
    frame(32'hdeadbeef, 32'h00000000);
    rchk("match flag", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0080);
    rchk("match status", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h8100);
    check("match line", 16'h0000, {15'h0, pme_line_n});
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h0000);
    prog(8'h02, 8'h91, 16'h00ef, 16'h0000);
    wr(SP_CFG, wk_pkg::PM_CSR_OFF, 16'h0100);
    wr(SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0080);
    wr(SP_BCR, wk_pkg::PAT_ADDR_IDX, 16'h0080);
    frame(32'h00000000, 32'h123456ef);
    rchk("skip mask flag", SP_CSR, wk_pkg::WAKE_CSR_IDX, 16'h0080);
    rchk("skip mask status", SP_CFG, wk_pkg::PM_CSR_OFF, 16'h8100);
    done("match");
  endtask

  task automatic summarize;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #100us;
    miscompares++;
    $display("[FAIL] watchdog expected end seen timeout");
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    cfg_load = 1'b0;
    cfg_lcm = 1'b0;
    mii = 1'b0;
    link_up = 1'b0;
    wf_det = 1'b0;
    rx_valid = 1'b0;
    rx_sof = 1'b0;
    rx_eof = 1'b0;
    rx_data = 32'h00000000;
    miscompares = 0;
    tests_run = 0;
    repeat (16) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_load();
    t_ram();
    t_retain();
    t_wake_frame();
    t_link();
    t_match();
    summarize();
  end
endmodule  // wake_event_pattern_match_test
`default_nettype wire

// ===== tb/wk_host.sv
// Host model: register accesses in the three spaces and the pulled-up wake line.
// Assumes one clock shared with the block; strobes are sampled on rising edges.
`default_nettype none
module wk_host (
  // Clock.
  input  wire logic        clk,
  // Register port, one strobe bit per space: config, control, bus config.
  output var logic [2:0]   wr_stb,
  output var logic [2:0]   rd_stb,
  output var logic [7:0]   reg_addr,
  output var logic [15:0]  reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  // Wake line.
  input  wire logic        pme_o,
  input  wire logic        pme_oe,
  output wire logic        pme_line_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // The board pull-up holds the line high whenever the block lets go.
  assign pme_line_n = pme_oe ? pme_o : 1'b1;
  initial begin
    wr_stb = 3'h0;
    rd_stb = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
  end
  task automatic wr(input logic [1:0] k, input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    wr_stb = 3'h1 << k;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    wr_stb = 3'h0;
    reg_wdata = ~d;
  endtask
  // A missing answer reads back as unknown so that no compare can pass.
  task automatic rd(input logic [1:0] k, input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    #1;
    rd_stb = 3'h1 << k;
    reg_addr = a;
    @(posedge clk);
    #1;
    rd_stb = 3'h0;
    d = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
  endtask
endmodule  // wk_host
`default_nettype wire
